/* File: rtl/cpu_test_transfer_decode.sv */
// Purpose: fetch, decode and execute the test and transfer instruction group
// Assumes: memory answers a read combinationally in the cycle it is asked
// Notes: cycle 0 of every instruction is its opcode fetch; done marks the last
`timescale 1ns/10ps

// Summary of operation
// RULE1: register test, one cycle, V cleared, N Z
// RULE2: direct test: one address byte, three cycles
// RULE3: index test, no operand, two cycles
// RULE4: byte offset test: index plus offset, three cycles
// RULE5: prefixed stack offset test, four cycles
// RULE6: stack to index: pointer plus one, two cycles
// RULE7: low index to accumulator, one cycle
// RULE8: index to stack: pair minus one, two cycles
// RULE9: absolute address fetched high byte first
// RULE10: word offset high first, added to index
// RULE11: index post increment after the access
// RULE12: byte offset access, then index increment
// RULE13: move direct to index, then increment
// RULE14: move index to direct, then increment
// RULE15: move immediate byte to direct location
// RULE16: move between two direct locations
// RULE17: relative branch adds one offset byte
// RULE18: memory tests read only, flags only change
module cpu_test_transfer_decode #(
    parameter int ADDR_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] mem_rdata,
    output logic [ADDR_W-1:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    output logic instr_done,
    output logic illegal_op,
    output logic [7:0] acc,
    output logic [15:0] index_pair,
    output logic [15:0] stack_ptr,
    output logic [15:0] prog_ctr,
    output logic [7:0] condition_flags
);

    if (ADDR_W != 16) begin : g_bad_width
        $error("address width must be 16");
    end

    test_xfer_pkg::seq_state_t state_q, state_d;
    logic [7:0] op_q, op_d;
    logic pre_q, pre_d;
    logic [2:0] step_q, step_d;
    logic [7:0] b1_q, b1_d, b2_q, b2_d, data_q, data_d;
    logic [7:0] acc_q, acc_d, flags_q, flags_d;
    logic [15:0] ix_q, ix_d, sp_q, sp_d, pc_q, pc_d;
    logic [7:0] test_val, flags_tested;
    logic do_fetch, cbeq_off;
    logic [15:0] off_word, off_byte, rel_b2;

    test_flag_update u_flags (
        .value(test_val),
        .flags_in(flags_q),
        .flags_out(flags_tested)
    );

    assign off_word = ix_q + {b1_q, b2_q};
    assign off_byte = ix_q + {8'h00, b2_q};
    assign rel_b2 = pc_q + {{8{b2_q[7]}}, b2_q};
    assign cbeq_off = (op_q == test_xfer_pkg::OP_CBEQ_IX1P);

    always_comb begin
        state_d = state_q;
        op_d = op_q;
        pre_d = pre_q;
        step_d = step_q;
        b1_d = b1_q;
        b2_d = b2_q;
        data_d = data_q;
        acc_d = acc_q;
        flags_d = flags_q;
        ix_d = ix_q;
        sp_d = sp_q;
        pc_d = pc_q;
        test_val = mem_rdata;
        do_fetch = 1'b0;
        mem_addr = pc_q;
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        mem_wdata = 8'h00;
        instr_done = 1'b0;
        illegal_op = 1'b0;
        case (state_q)
            test_xfer_pkg::ST_FETCH: begin
                mem_rd = 1'b1;
                pc_d = pc_q + 16'h0001;
                pre_d = 1'b0;
                op_d = mem_rdata;
                step_d = 3'h1;
                case (mem_rdata)
                    test_xfer_pkg::OP_TST_ACC, test_xfer_pkg::OP_TST_XLO: begin
                        test_val = (mem_rdata == test_xfer_pkg::OP_TST_ACC) ? acc_q : ix_q[7:0];
                        flags_d = flags_tested; // RULE1
                        instr_done = 1'b1;
                    end
                    test_xfer_pkg::OP_XLO_TO_A: begin
                        acc_d = ix_q[7:0]; // RULE7
                        instr_done = 1'b1;
                    end
                    test_xfer_pkg::OP_PREFIX: begin
                        state_d = test_xfer_pkg::ST_PREFIX; // RULE5
                    end
                    test_xfer_pkg::OP_TST_DIR, test_xfer_pkg::OP_TST_IX, test_xfer_pkg::OP_TST_IX1,
                    test_xfer_pkg::OP_SP_TO_HX, test_xfer_pkg::OP_HX_TO_SP, test_xfer_pkg::OP_LDA_ABS,
                    test_xfer_pkg::OP_LDA_IX2, test_xfer_pkg::OP_MOV_DD, test_xfer_pkg::OP_MOV_DIXP,
                    test_xfer_pkg::OP_MOV_IMD, test_xfer_pkg::OP_MOV_IXPD, test_xfer_pkg::OP_CBEQ_IXP,
                    test_xfer_pkg::OP_CBEQ_IX1P, test_xfer_pkg::OP_BRA: begin
                        state_d = test_xfer_pkg::ST_RUN;
                    end
                    default: begin
                        illegal_op = 1'b1;
                        instr_done = 1'b1;
                    end
                endcase
            end
            test_xfer_pkg::ST_PREFIX: begin
                mem_rd = 1'b1;
                pc_d = pc_q + 16'h0001;
                op_d = mem_rdata;
                if (mem_rdata == test_xfer_pkg::OP_TST_SP1) begin
                    pre_d = 1'b1; // RULE5
                    step_d = 3'h2;
                    state_d = test_xfer_pkg::ST_RUN;
                end else begin
                    illegal_op = 1'b1;
                    instr_done = 1'b1;
                    state_d = test_xfer_pkg::ST_FETCH;
                end
            end
            test_xfer_pkg::ST_RUN: begin
                step_d = step_q + 3'h1;
                case (op_q)
                    test_xfer_pkg::OP_TST_DIR: begin
                        if (step_q == 3'h1) begin
                            do_fetch = 1'b1;
                        end else begin
                            mem_rd = 1'b1; // RULE18
                            mem_addr = {test_xfer_pkg::DIRECT_PAGE_HI, b2_q}; // RULE2
                            flags_d = flags_tested;
                            instr_done = 1'b1;
                        end
                    end
                    test_xfer_pkg::OP_TST_IX: begin
                        mem_rd = 1'b1; // RULE18
                        mem_addr = ix_q; // RULE3
                        flags_d = flags_tested;
                        instr_done = 1'b1;
                    end
                    test_xfer_pkg::OP_TST_IX1: begin
                        if (step_q == (pre_q ? 3'h2 : 3'h1)) begin
                            do_fetch = 1'b1;
                        end else begin
                            mem_rd = 1'b1; // RULE18
                            mem_addr = pre_q ? sp_q + {8'h00, b2_q} : off_byte; // RULE4 RULE5
                            flags_d = flags_tested;
                            instr_done = 1'b1;
                        end
                    end
                    test_xfer_pkg::OP_SP_TO_HX: begin
                        ix_d = sp_q + 16'h0001; // RULE6
                        instr_done = 1'b1;
                    end
                    test_xfer_pkg::OP_HX_TO_SP: begin
                        sp_d = ix_q - 16'h0001; // RULE8
                        instr_done = 1'b1;
                    end
                    test_xfer_pkg::OP_LDA_ABS, test_xfer_pkg::OP_LDA_IX2: begin
                        if (step_q != 3'h3) begin
                            do_fetch = 1'b1; // RULE9 RULE10
                        end else begin
                            mem_rd = 1'b1;
                            mem_addr = (op_q == test_xfer_pkg::OP_LDA_ABS) ? {b1_q, b2_q} : off_word; // RULE9 RULE10
                            acc_d = mem_rdata;
                            flags_d = flags_tested;
                            instr_done = 1'b1;
                        end
                    end
                    test_xfer_pkg::OP_MOV_DD: begin
                        if (step_q < 3'h3) begin
                            do_fetch = 1'b1;
                        end else if (step_q == 3'h3) begin
                            mem_rd = 1'b1;
                            mem_addr = {test_xfer_pkg::DIRECT_PAGE_HI, b1_q}; // RULE16
                            data_d = mem_rdata;
                        end else begin
                            mem_wr = 1'b1;
                            mem_addr = {test_xfer_pkg::DIRECT_PAGE_HI, b2_q}; // RULE16
                            mem_wdata = data_q;
                            test_val = data_q;
                            flags_d = flags_tested;
                            instr_done = 1'b1;
                        end
                    end
                    test_xfer_pkg::OP_MOV_IMD: begin
                        if (step_q < 3'h3) begin
                            do_fetch = 1'b1;
                        end else begin
                            mem_wr = 1'b1;
                            mem_addr = {test_xfer_pkg::DIRECT_PAGE_HI, b2_q}; // RULE15
                            mem_wdata = b1_q;
                            test_val = b1_q;
                            flags_d = flags_tested;
                            instr_done = 1'b1;
                        end
                    end
                    test_xfer_pkg::OP_MOV_DIXP, test_xfer_pkg::OP_MOV_IXPD: begin
                        if (step_q == 3'h1) begin
                            do_fetch = 1'b1;
                        end else if (step_q == 3'h2) begin
                            mem_rd = 1'b1;
                            mem_addr = (op_q == test_xfer_pkg::OP_MOV_DIXP) ?
                                {test_xfer_pkg::DIRECT_PAGE_HI, b2_q} : ix_q; // RULE13 RULE14
                            data_d = mem_rdata;
                        end else begin
                            mem_wr = 1'b1;
                            mem_addr = (op_q == test_xfer_pkg::OP_MOV_DIXP) ?
                                ix_q : {test_xfer_pkg::DIRECT_PAGE_HI, b2_q}; // RULE13 RULE14
                            mem_wdata = data_q;
                            test_val = data_q;
                            flags_d = flags_tested;
                            ix_d = ix_q + 16'h0001; // RULE13 RULE14
                            instr_done = 1'b1;
                        end
                    end
                    test_xfer_pkg::OP_CBEQ_IXP, test_xfer_pkg::OP_CBEQ_IX1P: begin
                        if (step_q < (cbeq_off ? 3'h3 : 3'h2)) begin
                            do_fetch = 1'b1;
                        end else if (step_q == (cbeq_off ? 3'h3 : 3'h2)) begin
                            mem_rd = 1'b1;
                            mem_addr = cbeq_off ? ix_q + {8'h00, b1_q} : ix_q; // RULE11 RULE12
                            data_d = mem_rdata;
                        end else begin
                            ix_d = ix_q + 16'h0001; // RULE11 RULE12
                            if (data_q == acc_q) begin
                                pc_d = rel_b2; // RULE17
                            end
                            instr_done = 1'b1;
                        end
                    end
                    test_xfer_pkg::OP_BRA: begin
                        if (step_q == 3'h1) begin
                            do_fetch = 1'b1;
                        end else begin
                            pc_d = rel_b2; // RULE17
                            instr_done = 1'b1;
                        end
                    end
                    default: begin
                        instr_done = 1'b1;
                    end
                endcase
                // operand bytes shift in so a two-byte field lands high:low
                if (do_fetch) begin
                    mem_rd = 1'b1;
                    mem_addr = pc_q;
                    pc_d = pc_q + 16'h0001;
                    b1_d = b2_q; // RULE9 RULE10
                    b2_d = mem_rdata;
                end
                if (instr_done) begin
                    state_d = test_xfer_pkg::ST_FETCH;
                end
            end
            default: begin
                state_d = test_xfer_pkg::ST_FETCH;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= test_xfer_pkg::ST_FETCH;
            op_q <= 8'h00;
            pre_q <= 1'b0;
            step_q <= 3'h0;
            b1_q <= 8'h00;
            b2_q <= 8'h00;
            data_q <= 8'h00;
            acc_q <= 8'h00;
            flags_q <= test_xfer_pkg::FLAGS_RST;
            ix_q <= 16'h0000;
            sp_q <= test_xfer_pkg::SP_RST;
            pc_q <= test_xfer_pkg::PC_RST;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            pre_q <= pre_d;
            step_q <= step_d;
            b1_q <= b1_d;
            b2_q <= b2_d;
            data_q <= data_d;
            acc_q <= acc_d;
            flags_q <= flags_d;
            ix_q <= ix_d;
            sp_q <= sp_d;
            pc_q <= pc_d;
        end
    end
    assign acc = acc_q;
    assign index_pair = ix_q;
    assign stack_ptr = sp_q;
    assign prog_ctr = pc_q;
    assign condition_flags = flags_q;
    logic at_fetch;
    assign at_fetch = (state_q == test_xfer_pkg::ST_FETCH);
    a_tst_reg_flags: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE1
        at_fetch && mem_rdata == test_xfer_pkg::OP_TST_ACC |-> instr_done ##1
        (!condition_flags[test_xfer_pkg::FLAG_V] && condition_flags[test_xfer_pkg::FLAG_N] == $past(acc[7])
        && condition_flags[test_xfer_pkg::FLAG_Z] == ($past(acc) == 8'h00)
        && condition_flags[test_xfer_pkg::FLAG_C] == $past(condition_flags[test_xfer_pkg::FLAG_C])))
        else $error("register test flags wrong");
    a_tst_dir_len: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE2
        at_fetch && mem_rdata == test_xfer_pkg::OP_TST_DIR |=> (!instr_done && mem_rd && mem_addr == prog_ctr)
        ##1 (instr_done && mem_rd && mem_addr == {8'h00, $past(mem_rdata)}))
        else $error("direct test sequence wrong");
    a_tst_ix_len: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE3
        at_fetch && mem_rdata == test_xfer_pkg::OP_TST_IX |=> instr_done && mem_rd && mem_addr == index_pair)
        else $error("index test sequence wrong");
    a_tst_ix1_addr: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
        at_fetch && mem_rdata == test_xfer_pkg::OP_TST_IX1 |=> !instr_done
        ##1 (instr_done && mem_addr == index_pair + {8'h00, $past(mem_rdata)}))
        else $error("byte offset test address wrong");
    a_tst_sp1_len: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE5
        at_fetch && mem_rdata == test_xfer_pkg::OP_PREFIX ##1 mem_rdata == test_xfer_pkg::OP_TST_SP1
        |=> !instr_done ##1 (instr_done && mem_addr == stack_ptr + {8'h00, $past(mem_rdata)}))
        else $error("stack offset test wrong");
    a_sp_to_hx: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE6
        at_fetch && mem_rdata == test_xfer_pkg::OP_SP_TO_HX |=> instr_done
        ##1 (index_pair == stack_ptr + 16'h0001 && $stable(condition_flags)))
        else $error("stack to index transfer wrong");
    a_xlo_to_acc: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
        at_fetch && mem_rdata == test_xfer_pkg::OP_XLO_TO_A |-> instr_done
        ##1 (acc == $past(index_pair[7:0]) && $stable(condition_flags)))
        else $error("index to accumulator wrong");
    a_hx_to_sp: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE8
        at_fetch && mem_rdata == test_xfer_pkg::OP_HX_TO_SP |=> instr_done
        ##1 (stack_ptr == index_pair - 16'h0001 && $stable(condition_flags)))
        else $error("index to stack transfer wrong");
    a_abs_byte_order: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE9
        at_fetch && mem_rdata == test_xfer_pkg::OP_LDA_ABS |=> ##2
        (instr_done && mem_addr == {$past(mem_rdata, 2), $past(mem_rdata)}))
        else $error("absolute address byte order wrong");
    a_postinc_index: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE13
        at_fetch && mem_rdata == test_xfer_pkg::OP_MOV_DIXP |=> ##2
        (mem_wr && mem_addr == index_pair) ##1 (index_pair == $past(index_pair) + 16'h0001))
        else $error("post increment move wrong");
    a_tst_read_only: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE18
        state_q == test_xfer_pkg::ST_RUN && (op_q == test_xfer_pkg::OP_TST_DIR
        || op_q == test_xfer_pkg::OP_TST_IX || op_q == test_xfer_pkg::OP_TST_IX1)
        |-> !mem_wr ##1 ($stable(acc) && $stable(index_pair) && $stable(stack_ptr)))
        else $error("memory test changed state");
    c_tst_dir: cover property (@(posedge clk_sys) disable iff (!rst_n)
        at_fetch && mem_rdata == test_xfer_pkg::OP_TST_DIR ##2 instr_done);
    c_mov_dd: cover property (@(posedge clk_sys) disable iff (!rst_n)
        at_fetch && mem_rdata == test_xfer_pkg::OP_MOV_DD ##4 mem_wr);
    c_branch: cover property (@(posedge clk_sys) disable iff (!rst_n)
        at_fetch && mem_rdata == test_xfer_pkg::OP_BRA ##2 instr_done);

endmodule

/* File: rtl/test_flag_update.sv */
// Purpose: condition flag result of a negative-or-zero test
// Assumes: pure combinational, used for tests, loads and moves
// Notes: half-carry, mask and carry pass through untouched
`timescale 1ns/10ps
module test_flag_update (
    input wire logic [7:0] value,
    input wire logic [7:0] flags_in,
    output logic [7:0] flags_out
);

    always_comb begin
        flags_out = flags_in;
        flags_out[test_xfer_pkg::FLAG_V] = 1'b0;
        flags_out[test_xfer_pkg::FLAG_N] = value[7];
        flags_out[test_xfer_pkg::FLAG_Z] = (value == 8'h00);
    end

endmodule

/* File: rtl/test_xfer_pkg.sv */
// Purpose: shared constants for the test and transfer decode block
// Assumes: 8-bit data, 16-bit addresses, one byte moved per cycle
// Notes: opcode values and cycle totals are the instruction set's own
package test_xfer_pkg;

    // opcodes, first byte; OP_TST_SP1 is the byte after OP_PREFIX
    localparam logic [7:0] OP_TST_DIR = 8'h3D;
    localparam logic [7:0] OP_TST_ACC = 8'h4D;
    localparam logic [7:0] OP_TST_XLO = 8'h5D;
    localparam logic [7:0] OP_TST_IX1 = 8'h6D;
    localparam logic [7:0] OP_TST_IX = 8'h7D;
    localparam logic [7:0] OP_PREFIX = 8'h9E;
    localparam logic [7:0] OP_TST_SP1 = 8'h6D;
    localparam logic [7:0] OP_SP_TO_HX = 8'h95;
    localparam logic [7:0] OP_XLO_TO_A = 8'h9F;
    localparam logic [7:0] OP_HX_TO_SP = 8'h94;
    localparam logic [7:0] OP_LDA_ABS = 8'hC6;
    localparam logic [7:0] OP_LDA_IX2 = 8'hD6;
    localparam logic [7:0] OP_MOV_DD = 8'h4E;
    localparam logic [7:0] OP_MOV_DIXP = 8'h5E;
    localparam logic [7:0] OP_MOV_IMD = 8'h6E;
    localparam logic [7:0] OP_MOV_IXPD = 8'h7E;
    localparam logic [7:0] OP_CBEQ_IXP = 8'h71;
    localparam logic [7:0] OP_CBEQ_IX1P = 8'h61;
    localparam logic [7:0] OP_BRA = 8'h20;

    // cycles per instruction, opcode fetch included
    localparam int CYC_TST_REG = 1;
    localparam int CYC_TST_DIR = 3;
    localparam int CYC_TST_IX = 2;
    localparam int CYC_TST_IX1 = 3;
    localparam int CYC_TST_SP1 = 4;
    localparam int CYC_XFER_SP = 2;
    localparam int CYC_XLO_TO_A = 1;

    // flag byte layout
    localparam int FLAG_V = 7;
    localparam int FLAG_H = 4;
    localparam int FLAG_I = 3;
    localparam int FLAG_N = 2;
    localparam int FLAG_Z = 1;
    localparam int FLAG_C = 0;

    // values after reset, and the fixed direct page high byte
    localparam logic [7:0] FLAGS_RST = 8'h68;
    localparam logic [15:0] SP_RST = 16'h00FF;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] DIRECT_PAGE_HI = 8'h00;

    typedef enum logic [2:0] {
        ST_FETCH = 3'b001,
        ST_PREFIX = 3'b010,
        ST_RUN = 3'b100
    } seq_state_t;

endpackage

/* File: verification/mem_partner.sv */
// Purpose: zero-wait memory on the far side of the fetch and data bus
// Assumes: read answered in the same cycle, write taken at the rising edge
// Notes: when not read, the data lines show the inverse of the last byte read
`timescale 1ns/10ps
module mem_partner (
    input wire logic clk_sys,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q;
    // idle bus must not keep showing the last byte
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;
    always @(posedge clk_sys) begin
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
        if (mem_rd) begin
            last_q <= mem[mem_addr];
        end
    end
endmodule

/* File: verification/tb_top.sv */
// Purpose: self-checking run of the test, transfer, load and move group
// Assumes: program and data preloaded into the memory model before reset ends
// Notes: flags expected from tested values; compare-branch flags left unchecked
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] mem_rdata, acc, condition_flags, mem_wdata, exp_f;
    logic [15:0] mem_addr, index_pair, stack_ptr, prog_ctr, pc_exp;
    logic mem_rd, mem_wr, instr_done, illegal_op;
    logic [7:0] r [0:7];
    logic [7:0] prog [$];
    int err_total = 0;
    int n_tests = 0;
    int cyc_cnt = 0;
    always #2.5 clk_sys = ~clk_sys;
    cpu_test_transfer_decode i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .mem_rdata(mem_rdata),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .instr_done(instr_done), .illegal_op(illegal_op), .acc(acc), .index_pair(index_pair),
        .stack_ptr(stack_ptr), .prog_ctr(prog_ctr), .condition_flags(condition_flags));
    mem_partner i_mem (.clk_sys(clk_sys), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // entered at the falling edge of the opcode fetch cycle, left at the next one
    // mode 0 keeps flags, 1 sets V=0 N Z from val, 2 skips the flag check, 3 refused opcode
    task automatic step(input int cyc, input int len, input int nwr, input int mode, input logic [7:0] val);
        int n;
        int w;
        logic ill;
        n = 1;
        w = int'(mem_wr === 1'b1);
        while (instr_done !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
            w += int'(mem_wr === 1'b1);
        end
        ill = illegal_op;
        @(posedge clk_sys);
        #1;
        pc_exp = pc_exp + 16'(len);
        if (mode == 1) exp_f = {1'b0, exp_f[6:3], val[7], val == 8'h00, exp_f[0]};
        `CHK(n, cyc)
        `CHK(w, nwr)
        `CHK(ill, (mode == 3))
        `CHK(prog_ctr, pc_exp)
        if (mode != 2) `CHK(condition_flags, exp_f)
        @(negedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        cyc_cnt++;
        if (cyc_cnt == 500) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        void'($urandom(32'hA080EA06));
        foreach (r[i]) r[i] = 8'($urandom);
        r[2] = 8'h00;
        r[3] = r[3] | 8'h80;
        prog = {8'h95, 8'h94, 8'h5D, 8'hC6, 8'h00, 8'h40, 8'h4D, 8'h7D, 8'h3D, 8'h41, 8'h6D, 8'h05,
            8'h9E, 8'h6D, 8'h10, 8'h9F, 8'hD6, 8'h00, 8'h20, 8'h6E, r[6], 8'h42, 8'h4E, 8'h42, 8'h43,
            8'h5E, 8'h43, 8'h7E, 8'h44, 8'h20, 8'h02, 8'h00, 8'h00, 8'h71, 8'h02, 8'h00, 8'h00,
            8'h61, 8'hFF, 8'h02, 8'h00, 8'h9E, 8'h00};
        foreach (prog[i]) i_mem.mem[i] = prog[i];
        i_mem.mem[16'h0040] = r[0];
        i_mem.mem[16'h0041] = r[2];
        i_mem.mem[16'h0100] = r[1];
        i_mem.mem[16'h0101] = r[7];
        i_mem.mem[16'h0102] = r[5];
        i_mem.mem[16'h0105] = r[3];
        i_mem.mem[16'h010F] = r[4];
        i_mem.mem[16'h0120] = r[5];
        i_mem.mem[16'h0202] = ~r[5];
        pc_exp = 16'h0000;
        exp_f = 8'h68;
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        step(2, 1, 0, 0, 8'h00); `CHK(index_pair, 16'h0100)
        step(2, 1, 0, 0, 8'h00); `CHK(stack_ptr, 16'h00FF)
        step(1, 1, 0, 1, 8'h00);
        step(4, 3, 0, 1, r[0]); `CHK(acc, r[0])
        step(1, 1, 0, 1, r[0]);
        step(2, 1, 0, 1, r[1]);
        step(3, 2, 0, 1, r[2]);
        step(3, 2, 0, 1, r[3]);
        step(4, 3, 0, 1, r[4]); `CHK(acc, r[0])
        `CHK(index_pair, 16'h0100)
        step(1, 1, 0, 0, 8'h00); `CHK(acc, 8'h00)
        step(4, 3, 0, 1, r[5]); `CHK(acc, r[5])
        step(4, 3, 1, 1, r[6]); `CHK(i_mem.mem[16'h0042], r[6])
        step(5, 3, 1, 1, r[6]); `CHK(i_mem.mem[16'h0043], r[6])
        step(4, 2, 1, 1, r[6]); `CHK(i_mem.mem[16'h0100], r[6])
        `CHK(index_pair, 16'h0101)
        step(4, 2, 1, 1, r[7]); `CHK(i_mem.mem[16'h0044], r[7])
        `CHK(index_pair, 16'h0102)
        step(3, 4, 0, 0, 8'h00);
        step(4, 4, 0, 2, 8'h00); `CHK(index_pair, 16'h0103)
        step(5, 3, 0, 2, 8'h00); `CHK(index_pair, 16'h0104)
        step(1, 1, 0, 3, 8'h00); step(2, 2, 0, 3, 8'h00);
        summarize();
    end
endmodule
